// >>> hdl/spsc_core.sv
// Serial-programmed single-modulus PLL synthesizer core: shift register, latches,
// reference and feedback dividers, phase detectors, lock indicator, switch outputs.
// Assumes ref/feedback/serial inputs are synchronous to clock_i and slower than it.
// Summary of operation
// - Reference divided by 16,512,1024,2048,3668,4096,6144 or 8192 per 3-bit select.
// - Each serial clock rising edge shifts the data bit into a 16-bit register.
// - Word holds a 14-bit feedback divide value and two band-switch bits only.
// - Strobe high makes latches transparent to divider value and switch outputs.
// - Strobe low holds latches so shifting does not disturb outputs.
// - Undriven strobe reads high via pull-up, latches transparent.
// - Single-ended output: low pulses when feedback leads, high when lags, else float.
// - Feedback leading or faster: feedback-side output pulses low, reference side high.
// - Feedback lagging or slower: reference-side output pulses low, feedback side high.
// - In lock both double-ended outputs high except brief simultaneous low pulse.
// - Lock indicator high while in lock, pulses low when out of lock.
// - Band-switch outputs are latched open-drain from serial bits one and two.
// - Latched 1 releases the switch output, latched 0 drives it low.
// - Buffered copy of the reference input is provided.
// - Serial port works with a standard SPI master driving clock and data.
`timescale 1ns/1ps
`default_nettype none
module spsc_core
    import spsc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic ref_osc_input_i,
    input  wire logic feedback_in_i,
    input  wire logic serial_clk_i,
    input  wire logic serial_data_i,
    input  wire logic latch_transfer_strobe_i,
    input  wire logic latch_transfer_strobe_driven_i,
    input  wire logic ref_select_bit0_i,
    input  wire logic ref_select_bit1_i,
    input  wire logic ref_select_bit2_i,
    output logic      buffered_reference_output_o,
    output logic      single_ended_phase_error_o,
    output logic      single_ended_phase_error_oe_o,
    output logic      phase_ref_n_o,
    output logic      phase_fb_n_o,
    output logic      lock_indicator_o,
    output logic      band_switch_a_o,
    output logic      band_switch_a_oe_o,
    output logic      band_switch_b_o,
    output logic      band_switch_b_oe_o,
    output logic      divided_reference_freq_o,
    output logic      divided_feedback_freq_o
);

    // Edge detection on the slow inputs
    logic                   ref_d;
    logic                   fb_d;
    logic                   sclk_d;
    logic                   ref_rise;
    logic                   fb_rise;
    logic                   sclk_rise;
    logic                   strobe_eff;

    logic [SPSC_WORD_W-1:0] shift_reg;
    logic [SPSC_WORD_W-1:0] next_shift_reg;
    logic [SPSC_N_W-1:0]    n_latch;
    logic [SPSC_N_W-1:0]    next_n_latch;
    logic [1:0]             sw_latch;
    logic [1:0]             next_sw_latch;

    logic [SPSC_R_W-1:0]    r_cnt;
    logic [SPSC_R_W-1:0]    next_r_cnt;
    logic [SPSC_N_W-1:0]    n_cnt;
    logic [SPSC_N_W-1:0]    next_n_cnt;
    logic                   fr_tick;
    logic                   fv_tick;
    logic                   fr_tgl;
    logic                   next_fr_tgl;
    logic                   fv_tgl;
    logic                   next_fv_tgl;

    spsc_pd_t               pd_state;
    spsc_pd_t               next_pd_state;
    logic                   pd_up;
    logic                   next_pd_up;
    logic                   pd_dn;
    logic                   next_pd_dn;
    logic                   ref_buf;

    function automatic logic [SPSC_R_W-1:0] r_ratio(input logic [SPSC_SEL_W-1:0] sel);
        r_ratio = SPSC_R_DIV[sel];
    endfunction : r_ratio

    // Floating strobe reads as pulled up
    assign strobe_eff = latch_transfer_strobe_i | ~latch_transfer_strobe_driven_i;
    assign ref_rise   = ref_osc_input_i & ~ref_d;
    assign fb_rise    = feedback_in_i & ~fb_d;
    assign sclk_rise  = serial_clk_i & ~sclk_d;
    assign fr_tick    = ref_rise && (r_cnt == SPSC_R_ONE);
    assign fv_tick    = fb_rise && (n_cnt <= SPSC_N_ONE);

    // Shift register and latches
    always_comb
    begin
        next_shift_reg = shift_reg;
        next_n_latch   = n_latch;
        next_sw_latch  = sw_latch;
        if (sclk_rise)
        begin
            next_shift_reg = {shift_reg[SPSC_WORD_W-2:0], serial_data_i};
        end
        if (strobe_eff)
        begin
            // Transparent: new serial bits reach the outputs the same clock they land
            next_n_latch  = next_shift_reg[SPSC_N_LSB +: SPSC_N_W];
            next_sw_latch = {next_shift_reg[SPSC_SW_B_POS], next_shift_reg[SPSC_SW_A_POS]};
        end // Held otherwise
    end

    // Dividers; reference runs free whatever the programming state
    always_comb
    begin
        next_r_cnt  = r_cnt;
        next_n_cnt  = n_cnt;
        next_fr_tgl = fr_tgl;
        next_fv_tgl = fv_tgl;
        if (ref_rise)
        begin
            if (r_cnt <= SPSC_R_ONE)
            begin
                next_r_cnt  = r_ratio({ref_select_bit2_i, ref_select_bit1_i, ref_select_bit0_i});
                next_fr_tgl = ~fr_tgl;
            end
            else
            begin
                next_r_cnt = r_cnt - SPSC_R_ONE;
            end
        end
        if (fb_rise)
        begin
            // Values below 3 are outside the host's range; no protection is added
            if (n_cnt <= SPSC_N_ONE)
            begin
                next_n_cnt  = n_latch;
                next_fv_tgl = ~fv_tgl;
            end
            else
            begin
                next_n_cnt = n_cnt - SPSC_N_ONE;
            end
        end
    end

    // Four-state phase-frequency detector; coincidence gives one clock on both
    always_comb
    begin
        next_pd_state = pd_state;
        next_pd_up    = 1'b0;
        next_pd_dn    = 1'b0;
        case (pd_state)
            SPSC_PD_IDLE:
            begin
                if (fr_tick && fv_tick)
                    next_pd_state = SPSC_PD_BOTH;
                else if (fr_tick)
                    next_pd_state = SPSC_PD_UP;
                else if (fv_tick)
                    next_pd_state = SPSC_PD_DOWN;
            end
            SPSC_PD_UP:
                if (fv_tick)
                    next_pd_state = SPSC_PD_BOTH;
            SPSC_PD_DOWN:
                if (fr_tick)
                    next_pd_state = SPSC_PD_BOTH;
            SPSC_PD_BOTH:
                next_pd_state = SPSC_PD_IDLE;
            default:
                next_pd_state = SPSC_PD_IDLE;
        endcase
        next_pd_up = (next_pd_state == SPSC_PD_UP);
        next_pd_dn = (next_pd_state == SPSC_PD_DOWN);
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ref_d     <= 1'b0;
            fb_d      <= 1'b0;
            sclk_d    <= 1'b0;
            shift_reg <= '0;
            n_latch   <= SPSC_N_RESET;
            sw_latch  <= SPSC_SW_RESET;
            r_cnt     <= SPSC_R_ONE;
            n_cnt     <= SPSC_N_ONE;
            fr_tgl    <= 1'b0;
            fv_tgl    <= 1'b0;
            pd_state  <= SPSC_PD_IDLE;
            pd_up     <= 1'b0;
            pd_dn     <= 1'b0;
            ref_buf   <= 1'b0;
        end
        else
        begin
            ref_d     <= ref_osc_input_i;
            fb_d      <= feedback_in_i;
            sclk_d    <= serial_clk_i;
            shift_reg <= next_shift_reg;
            n_latch   <= next_n_latch;
            sw_latch  <= next_sw_latch;
            r_cnt     <= next_r_cnt;
            n_cnt     <= next_n_cnt;
            fr_tgl    <= next_fr_tgl;
            fv_tgl    <= next_fv_tgl;
            pd_state  <= next_pd_state;
            pd_up     <= next_pd_up;
            pd_dn     <= next_pd_dn;
            ref_buf   <= ref_osc_input_i;
        end
    end

    wire both_pulse = (pd_state == SPSC_PD_BOTH);

    assign buffered_reference_output_o   = ref_buf;
    assign phase_ref_n_o                 = ~(pd_up | both_pulse);
    assign phase_fb_n_o                  = ~(pd_dn | both_pulse);
    assign single_ended_phase_error_o    = pd_up;
    assign single_ended_phase_error_oe_o = pd_up | pd_dn;
    assign lock_indicator_o              = ~(pd_up | pd_dn);
    // Open drain: data always low, enable when latched bit is zero
    assign band_switch_a_o               = 1'b0;
    assign band_switch_b_o               = 1'b0;
    assign band_switch_a_oe_o            = ~sw_latch[0];
    assign band_switch_b_oe_o            = ~sw_latch[1];
    assign divided_reference_freq_o      = fr_tgl;
    assign divided_feedback_freq_o       = fv_tgl;

    property p_pd_excl;
        @(posedge clock_i) disable iff (!rstn_i) !(pd_up && pd_dn);
    endproperty
    a_pd_excl: assert property (p_pd_excl) else $error("both error pulses at once");

    property p_fb_lead;
        @(posedge clock_i) disable iff (!rstn_i)
            (pd_state == SPSC_PD_IDLE && fv_tick && !fr_tick) |=> (!phase_fb_n_o && phase_ref_n_o);
    endproperty
    a_fb_lead: assert property (p_fb_lead) else $error("feedback lead not flagged");

    property p_fb_lag;
        @(posedge clock_i) disable iff (!rstn_i)
            (pd_state == SPSC_PD_IDLE && fr_tick && !fv_tick) |=> (!phase_ref_n_o && phase_fb_n_o);
    endproperty
    a_fb_lag: assert property (p_fb_lag) else $error("feedback lag not flagged");

    sequence s_coincide;
        (pd_state == SPSC_PD_IDLE && fr_tick && fv_tick);
    endsequence
    property p_coincide;
        @(posedge clock_i) disable iff (!rstn_i)
            s_coincide |=> (!phase_ref_n_o && !phase_fb_n_o) ##1 (phase_ref_n_o && phase_fb_n_o);
    endproperty
    a_coincide: assert property (p_coincide) else $error("coincidence pulse wrong");

    property p_lock;
        @(posedge clock_i) disable iff (!rstn_i)
            lock_indicator_o == (pd_state == SPSC_PD_IDLE || pd_state == SPSC_PD_BOTH);
    endproperty
    a_lock: assert property (p_lock) else $error("lock indicator mismatch");

    property p_se_drive;
        @(posedge clock_i) disable iff (!rstn_i)
            (pd_state == SPSC_PD_DOWN) |-> single_ended_phase_error_oe_o && !single_ended_phase_error_o;
    endproperty
    a_se_drive: assert property (p_se_drive) else $error("lead not driven low");

    property p_ref_buf;
        @(posedge clock_i) disable iff (!rstn_i)
            1'b1 |=> buffered_reference_output_o == $past(ref_osc_input_i);
    endproperty
    a_ref_buf: assert property (p_ref_buf) else $error("reference copy wrong");

    property p_hold;
        @(posedge clock_i) disable iff (!rstn_i) !strobe_eff |=> $stable(n_latch) && $stable(sw_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed while held");

    property p_transfer;
        @(posedge clock_i) disable iff (!rstn_i)
            strobe_eff |=> n_latch == shift_reg[SPSC_N_W-1:0] && band_switch_a_oe_o == !shift_reg[SPSC_SW_A_POS];
    endproperty
    a_transfer: assert property (p_transfer) else $error("latch not transparent");

    property p_switch_b;
        @(posedge clock_i) disable iff (!rstn_i)
            strobe_eff |=> band_switch_b_oe_o == !shift_reg[SPSC_SW_B_POS];
    endproperty
    a_switch_b: assert property (p_switch_b) else $error("second switch not latched");

    property p_shift;
        @(posedge clock_i) disable iff (!rstn_i)
            sclk_rise |=> shift_reg[0] == $past(serial_data_i) && shift_reg[SPSC_WORD_W-1:1] == $past(shift_reg[SPSC_WORD_W-2:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift register did not shift");

    property p_reload;
        @(posedge clock_i) disable iff (!rstn_i) fv_tick |=> n_cnt == $past(n_latch);
    endproperty
    a_reload: assert property (p_reload) else $error("feedback counter not reloaded");

endmodule : spsc_core
`default_nettype wire

// >>> hdl/spsc_pkg.sv
// Package for the serial PLL synthesizer core: widths, divide table, serial word layout.
// Assumes a single 100 MHz system clock; all pins are sampled synchronously.
package spsc_pkg;
    localparam int          SPSC_WORD_W     = 16;
    localparam int          SPSC_N_W        = 14;
    localparam int          SPSC_R_W        = 14;
    localparam int          SPSC_SEL_W      = 3;
    // Serial word layout, first bit shifted in ends up at the top
    localparam int          SPSC_SW_A_POS   = 15;
    localparam int          SPSC_SW_B_POS   = 14;
    localparam int          SPSC_N_LSB      = 0;
    localparam logic [13:0] SPSC_N_RESET    = 14'h3fff;
    localparam logic [1:0]  SPSC_SW_RESET   = 2'h3;
    localparam logic [13:0] SPSC_N_ONE      = 14'h0001;
    localparam logic [13:0] SPSC_R_ONE      = 14'h0001;
    // Width of the coincidence pulse on both double-ended outputs, in clocks
    localparam int          SPSC_MIN_PULSE  = 1;
    // Counter is one bit wider than 8191 so the largest ratio divides exactly
    localparam logic [13:0] SPSC_R_DIV [8] = '{14'h0010, 14'h0200, 14'h0400, 14'h0800,
                                               14'h0e54, 14'h1000, 14'h1800, 14'h2000};
    typedef enum logic [1:0] {SPSC_PD_IDLE, SPSC_PD_UP, SPSC_PD_DOWN, SPSC_PD_BOTH} spsc_pd_t;
endpackage : spsc_pkg

// >>> sim/spsc_core_tb.sv
// Bench for the serial PLL synthesizer core: loads, latch hold, dividers, phase and lock outputs.
// Assumes spsc_host_model drives the serial pins; all stimulus changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module spsc_core_tb;
    import spsc_pkg::*;
    logic       clock_i, rstn_i, ref_run, ref_fast, ref_osc, fb_in, drv;
    logic [1:0] fb_mode, cyc;
    logic [2:0] sel;
    int         ref_edges, fb_edges, errors, samples_checked;
    int         c_ref, c_fb, c_both, c_oe0, c_oe1, c_lock, c_buf;
    int         rdiv [5] = '{16, 512, 1024, 2048, 3668};
    wire logic  sck, sdat, stb, bref, pe, pe_oe, pr_n, pf_n, lock, sa, sa_oe, sb, sb_oe, fr, fv;
    wire logic  nref = ref_run & (ref_fast ? cyc[0] : cyc[1]);
    wire logic  nfb  = (fb_mode == 2'h1) ? nref : ((fb_mode == 2'h2) & cyc[0]);

    spsc_host_model spsc_host_model_inst (.clock_i(clock_i), .serial_clk_o(sck), .serial_data_o(sdat),
        .strobe_o(stb));
    // A floating strobe pin reads high through its pull-up
    spsc_core spsc_core_inst (
        .clock_i(clock_i), .rstn_i(rstn_i), .ref_osc_input_i(ref_osc), .feedback_in_i(fb_in),
        .serial_clk_i(sck), .serial_data_i(sdat), .latch_transfer_strobe_i(drv ? stb : 1'b1),
        .latch_transfer_strobe_driven_i(drv), .ref_select_bit0_i(sel[0]), .ref_select_bit1_i(sel[1]),
        .ref_select_bit2_i(sel[2]), .buffered_reference_output_o(bref), .single_ended_phase_error_o(pe),
        .single_ended_phase_error_oe_o(pe_oe), .phase_ref_n_o(pr_n), .phase_fb_n_o(pf_n),
        .lock_indicator_o(lock), .band_switch_a_o(sa), .band_switch_a_oe_o(sa_oe), .band_switch_b_o(sb),
        .band_switch_b_oe_o(sb_oe), .divided_reference_freq_o(fr), .divided_feedback_freq_o(fv));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Reference rises every 4 clocks, every 2 with ref_fast; fast feedback every 2
    always @(negedge clock_i)
    begin
        cyc       <= cyc + 2'h1;
        ref_osc   <= nref;
        fb_in     <= nfb;
        ref_edges += (nref & !ref_osc);
        fb_edges  += (nfb & !fb_in);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic observe(input int n);
        {c_ref, c_fb, c_both, c_oe0, c_oe1, c_lock, c_buf} = '0;
        repeat (n)
        begin
            @(posedge clock_i);
            #1;
            c_ref  += (pr_n === 1'b0) && (pf_n === 1'b1);
            c_fb   += (pr_n === 1'b1) && (pf_n === 1'b0);
            c_both += (pr_n === 1'b0) && (pf_n === 1'b0);
            c_oe0  += (pe_oe === 1'b1) && (pe === 1'b0);
            c_oe1  += (pe_oe === 1'b1) && (pe === 1'b1);
            c_lock += (lock !== 1'b1);
            c_buf  += (bref !== ref_osc);
        end
        @(negedge clock_i);
    endtask : observe

    // Skips the first interval, which may straddle a ratio change
    task automatic meas(input bit use_fb, input int exp);
        int n0;
        repeat (2)
        begin
            n0 = use_fb ? fb_edges : ref_edges;
            if (use_fb)
                @(fv);
            else
                @(fr);
        end
        n0 = (use_fb ? fb_edges : ref_edges) - n0;
        @(negedge clock_i);
        check(n0, exp);
    endtask : meas

    task automatic complete_run();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        #1_000_000;
        errors++;
        complete_run();
    end

    initial
    begin
        {rstn_i, ref_run, ref_fast, ref_osc, fb_in, fb_mode, cyc, sel} = '0;
        {ref_edges, fb_edges, errors, samples_checked} = '0;
        drv = 1'b1;
        repeat (4) @(negedge clock_i);
        rstn_i = 1'b1;
        @(negedge clock_i);
        check({sa_oe, sb_oe, sa, sb, pr_n, pf_n, lock, pe_oe}, 8'h0e);
        spsc_host_model_inst.load(1'b0, 1'b1, 14'h0010, 1'b1);
        @(negedge clock_i);
        check({sa_oe, sb_oe, sa, sb}, 4'h8);
        ref_run <= 1'b1;
        fb_mode <= 2'h1;
        observe(400);
        check(c_ref + c_fb, 0);
        check(c_both > 0, 1);
        check(c_oe0 + c_oe1, 0);
        check(c_lock, 0);
        check(c_buf, 0);
        meas(1'b1, 16);
        $display("load and lock test done");
        spsc_host_model_inst.load(1'b1, 1'b0, 14'h0003, 1'b0);
        @(negedge clock_i);
        check({sa_oe, sb_oe}, 2'h2);
        meas(1'b1, 16);
        drv <= 1'b0;
        repeat (2) @(negedge clock_i);
        check({sa_oe, sb_oe}, 2'h1);
        meas(1'b1, 3);
        drv <= 1'b1;
        $display("latch hold and float test done");
        fb_mode <= 2'h2;
        observe(100);
        observe(400);
        check(c_fb > 0, 1);
        check(c_ref, 0);
        check(c_oe0 > 0, 1);
        check(c_oe1, 0);
        check(c_lock > 0, 1);
        fb_mode <= 2'h0;
        observe(100);
        observe(400);
        check(c_ref > 0, 1);
        check(c_fb, 0);
        check(c_oe1 > 0, 1);
        check(c_oe0, 0);
        $display("phase detector test done");
        // Fastest reference keeps the long ratios inside the run budget
        ref_fast <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            sel <= k[2:0];
            meas(1'b0, rdiv[k]);
        end
        sel <= 3'h7;
        meas(1'b0, 8192);
        $display("reference divide test done");
        complete_run();
    end
endmodule : spsc_core_tb
`default_nettype wire

// >>> sim/spsc_host_model.sv
// Host model: shifts one 16-bit word into the core, then, when commit is set, commits it with a strobe pulse.
// Assumes clock_i is the bench clock; every output changes at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module spsc_host_model
(
    input  wire logic clock_i,
    output logic      serial_clk_o,
    output logic      serial_data_o,
    output logic      strobe_o
);
    initial
    begin
        serial_clk_o  = 1'b0;
        serial_data_o = 1'b0;
        strobe_o      = 1'b0;
    end

    task automatic load(input logic sw_a, input logic sw_b, input logic [13:0] n, input bit commit);
        logic [15:0] w;
        w = {sw_a, sw_b, n};
        for (int i = 15; i >= 0; i--)
        begin
            @(negedge clock_i);
            serial_clk_o  <= 1'b0;
            serial_data_o <= w[i];
            @(negedge clock_i);
            serial_clk_o  <= 1'b1;
        end
        @(negedge clock_i);
        serial_clk_o  <= 1'b0;
        // Data is stale after the frame, so show the opposite level
        serial_data_o <= ~w[0];
        if (commit)
        begin
            strobe_o <= 1'b1;
            repeat (2) @(negedge clock_i);
            strobe_o <= 1'b0;
        end
    endtask : load
endmodule : spsc_host_model
`default_nettype wire
